/* File: dpl_hdr_ecc.sv */
// Header check: recomputes six parity bits over the 24 header bits,
// corrects a single flipped bit and flags anything it cannot correct.
// Purely combinational; the caller samples it when the check byte arrives.
`timescale 1ns/1ns
module dpl_hdr_ecc (
  input wire logic [23:0] i_data,
  input wire logic [7:0] i_parity,
  output logic [23:0] o_data,
  output logic o_fixed,
  output logic o_fatal
);
  import dpl_pkg::*;

  logic [5:0] calc;
  logic [5:0] syn;
  logic hit;

  // Parity generation, one XOR tree per check bit.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      calc[k] = ^(i_data & ECC_MASK[k]);
    end
  end

  assign syn = calc ^ i_parity[5:0];

  // A syndrome equal to a data bit's column names that bit; a one-hot
  // syndrome means only a check bit flipped and the data stands.
  always_comb begin
    o_data = i_data;
    hit = 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (syn != 6'h00 && syn == {ECC_MASK[5][i], ECC_MASK[4][i], ECC_MASK[3][i],
                                  ECC_MASK[2][i], ECC_MASK[1][i], ECC_MASK[0][i]}) begin
        o_data[i] = ~i_data[i];
        hit = 1'b1;
      end
    end
    if (syn != 6'h00 && $onehot(syn)) begin
      hit = 1'b1;
    end
    o_fixed = hit;
    o_fatal = (syn != 6'h00) && !hit;
  end

endmodule

/* File: dpl_host_model.sv */
// Host-side model: drives the serial lane, the burst frame and lane-0 levels.
// Assumes the bench's 100 MHz clock; link clock 160 ns, still between bursts.
`timescale 1ns/1ns
module dpl_host_model (
  input wire logic i_clk_sys,
  input wire logic i_lp_oe,
  output logic o_link_clk,
  output logic o_burst,
  output logic o_lane_bit,
  output logic o_host_oe,
  output logic [1:0] o_host_lp
);
  import dpl_pkg::*;
  int to_err;

  // The host owns lane 0 in the stop state until it asks for a turnaround.
  initial begin
    o_link_clk = 1'b0;
    o_burst = 1'b0;
    o_lane_bit = 1'b0;
    o_host_oe = 1'b1;
    o_host_lp = LP_11;
    to_err = 0;
  end

  // packets back to back, LSB first
  task automatic burst(input logic [7:0] q[$]);
    @(posedge i_clk_sys) o_burst <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) begin
        o_link_clk <= 1'b0;
        o_lane_bit <= q[i][b];
        repeat (8) @(posedge i_clk_sys);
        o_link_clk <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
      end
    end
    // The clock stops low and the data line no longer holds the last bit.
    o_link_clk <= 1'b0;
    o_burst <= 1'b0;
    o_lane_bit <= ~o_lane_bit;
    repeat (40) @(posedge i_clk_sys);
  endtask

  // request from stop: LP-11, LP-10, LP-00
  task automatic turnaround();
    @(posedge i_clk_sys) o_host_lp <= LP_11;
    repeat (10) @(posedge i_clk_sys);
    o_host_lp <= LP_10;
    repeat (LPX_CYC) @(posedge i_clk_sys);
    o_host_lp <= LP_00;
    for (int n = 0; n < 200 && i_lp_oe !== 1'b1; n++) @(posedge i_clk_sys);
    if (i_lp_oe !== 1'b1) to_err++;
    o_host_oe <= 1'b0;
  endtask
endmodule

/* File: dpl_pkg.sv */
// Shared constants, field layouts and packet classification for the
// display-link packet receiver and its lane-0 turnaround logic.
// Assumes a single 100 MHz system clock shared by every user of the package.
package dpl_pkg;

  // System clock rate and the low-power step times derived from it.
  localparam int CLK_MHZ = 100;
  localparam int T_LPX_NS = 50;
  localparam int LPX_CYC = (T_LPX_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BTA_GO_NS = 200;
  localparam int BTA_GO_CYC = (T_BTA_GO_NS * CLK_MHZ + 999) / 1000;

  // Low-power line states, written as {dp, dn}.
  localparam logic [1:0] LP_11 = 2'b11;
  localparam logic [1:0] LP_10 = 2'b10;
  localparam logic [1:0] LP_00 = 2'b00;
  localparam logic [1:0] LP_01 = 2'b01;

  // Identifier byte layout and the only channel this receiver serves.
  localparam int VC_MSB = 7;
  localparam int VC_LSB = 6;
  localparam int DT_MSB = 5;
  localparam logic [1:0] VC_OWN = 2'b00;

  // Header and footer sizes in bytes.
  localparam int HDR_BYTES = 4;
  localparam int FOOT_BYTES = 2;
  localparam int BYTE_BITS = 8;

  // Footer checksum: x^16+x^12+x^5+1, processed bit-reversed, LSB first.
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;

  // Header check bit k is the XOR of the data bits set in ECC_MASK[k].
  localparam logic [5:0][23:0] ECC_MASK = {
    24'heffc00, 24'hdf03f0, 24'hb8e38e, 24'h749a6d, 24'hf2555b, 24'hf12cb7};

  // Long packets carry a byte count; their type codes end in 9h or eh.
  function automatic logic is_long_type(input logic [5:0] dt);
    return (dt[3:0] == 4'h9) || (dt[3:0] == 4'he);
  endfunction

  // Types a host may send to this display; anything else is ignored.
  function automatic logic is_host_type(input logic [5:0] dt);
    unique case (dt)
      6'h01, 6'h11, 6'h21, 6'h31, 6'h08, 6'h03, 6'h13, 6'h23,
      6'h04, 6'h14, 6'h24, 6'h05, 6'h15, 6'h06, 6'h37, 6'h09,
      6'h19, 6'h29, 6'h39, 6'h3e, 6'h0e, 6'h1e, 6'h2e: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

endpackage

/* File: dpl_rx_top.sv */
// Packet-level receiver of a display serial data lane with the lane-0
// bus turnaround handshake, as seen from inside the display.
// Assumes a lane layer ahead of it that raises i_burst after start-of-burst
// sync and drops it at end of burst; all link pins are asynchronous.
`timescale 1ns/1ns
module dpl_rx_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_burst,
  input wire logic i_lane_bit,
  input wire logic i_lp_dp,
  input wire logic i_lp_dn,
  output logic o_lp_dp,
  output logic o_lp_dn,
  output logic o_lp_oe,
  output logic o_lane_owned,
  input wire logic i_give_back,
  output logic o_short_valid,
  output logic [7:0] o_short_id,
  output logic [15:0] o_short_payload,
  output logic [5:0] o_long_type,
  output logic [7:0] o_data,
  output logic o_data_last,
  output logic o_data_valid,
  input wire logic i_data_ready,
  output logic o_hdr_fixed,
  output logic o_crc_err,
  output logic o_hdr_err,
  output logic o_overflow,
  input wire logic i_err_clr
);
  import dpl_pkg::*;

  typedef enum logic [2:0] {P_HDR, P_PAY, P_CRC, P_SKIP, P_DROP} dpl_pstate_t;
  typedef enum logic [3:0] {
    B_LISTEN, B_STOP, B_SAW10, B_SAW00, B_TAKE00, B_TAKE10, B_OWN, B_GIVE10, B_GIVE00
  } dpl_bstate_t;

  // Footer checksum over one byte, first bit in first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < BYTE_BITS; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction

  // Every link pin passes two flops; clk_d only ever reads the second.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic clk_d;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 5'h03;
      sync2 <= 5'h03;
      clk_d <= 1'b0;
    end else begin
      sync1 <= {i_link_clk, i_burst, i_lane_bit, i_lp_dp, i_lp_dn};
      sync2 <= sync1;
      clk_d <= sync2[4];
    end
  end

  wire link_rise = sync2[4] && !clk_d;
  wire burst = sync2[3];
  wire lane_bit = sync2[2];
  wire [1:0] lp_in = sync2[1:0];

  // packet bytes, first bit lowest.
  // Bytes shift in from the top so the first bit lands in bit 0.
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic byte_stb;
  logic [7:0] byte_q;
  wire [7:0] next_shreg = {lane_bit, shreg[7:1]};
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      byte_stb <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      byte_stb <= burst && link_rise && (bitcnt == 3'(BYTE_BITS - 1));
      if (!burst) begin
        bitcnt <= 3'h0;
      end else if (link_rise) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + 3'h1;
        if (bitcnt == 3'(BYTE_BITS - 1)) begin
          byte_q <= next_shreg;
        end
      end
    end
  end

  a_bit_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    byte_stb |-> byte_q[7] == $past(lane_bit) && byte_q[6] == $past(shreg[7]))
    else $error("byte not assembled least significant bit first");

  // Parser registers.
  dpl_pstate_t pstate;
  logic [1:0] hcnt;
  logic [23:0] hdr;
  logic [16:0] remain;
  logic [15:0] crc;
  logic [7:0] foot_lo;
  logic foot_cnt;

  wire hdr_done = byte_stb && (pstate == P_HDR) && (hcnt == 2'(HDR_BYTES - 1));
  wire [23:0] hdr_raw = hdr;
  wire [23:0] hdr_fix;
  wire ecc_fixed;
  wire ecc_fatal;
  dpl_hdr_ecc u_ecc (
    .i_data(hdr_raw),
    .i_parity(byte_q),
    .o_data(hdr_fix),
    .o_fixed(ecc_fixed),
    .o_fatal(ecc_fatal)
  );

  wire [1:0] hdr_vc = hdr_fix[VC_MSB:VC_LSB];
  wire [5:0] hdr_dt = hdr_fix[DT_MSB:0];
  wire [15:0] hdr_wc = hdr_fix[23:8];
  wire hdr_long = is_long_type(hdr_dt);
  wire hdr_keep = (hdr_vc == VC_OWN) && is_host_type(hdr_dt) && !ecc_fatal;

  // Payload path into the buffer; a byte refused by a full buffer is lost.
  wire pay_stb = byte_stb && (pstate == P_PAY);
  wire pay_last = (remain == 17'h00001);
  wire buf_ready;
  wire [8:0] buf_out;
  dpl_skid_buf #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(pay_stb),
    .i_data({pay_last, byte_q}),
    .o_ready(buf_ready),
    .o_valid(o_data_valid),
    .o_data(buf_out),
    .i_ready(i_data_ready)
  );
  assign o_data = buf_out[7:0];
  assign o_data_last = buf_out[8];

  // packet sequencing within a burst.
  // The burst falling always returns to header hunting, so a truncated
  // packet never swallows the start of the next burst.
  dpl_pstate_t next_pstate;
  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      P_HDR: begin
        if (hdr_done) begin
          if (ecc_fatal) begin
            next_pstate = P_DROP;
          end else if (hdr_long && hdr_wc == 16'h0000) begin
            next_pstate = hdr_keep ? P_CRC : P_SKIP;
          end else if (hdr_long) begin
            next_pstate = hdr_keep ? P_PAY : P_SKIP;
          end
        end
      end
      P_PAY: if (byte_stb && pay_last) next_pstate = P_CRC;
      P_CRC: if (byte_stb && foot_cnt) next_pstate = P_HDR;
      P_SKIP: if (byte_stb && remain == 17'h00001) next_pstate = P_HDR;
      P_DROP: next_pstate = P_DROP;
    endcase
    if (!burst) begin
      next_pstate = P_HDR;
    end
  end

  // header bytes gathered low byte first.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pstate <= P_HDR;
      hcnt <= 2'h0;
      hdr <= 24'h000000;
    end else begin
      pstate <= next_pstate;
      if (!burst || hdr_done) begin
        hcnt <= 2'h0;
      end else if (byte_stb && pstate == P_HDR) begin
        hcnt <= hcnt + 2'h1;
        hdr <= {byte_q, hdr[23:8]};
      end
    end
  end

  // byte count, checksum and footer handling.
  // A dropped long packet skips its payload plus footer.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      remain <= 17'h00000;
      crc <= CRC_SEED;
      foot_lo <= 8'h00;
      foot_cnt <= 1'b0;
    end else if (hdr_done) begin
      remain <= hdr_keep ? {1'b0, hdr_wc} : {1'b0, hdr_wc} + 17'(FOOT_BYTES);
      crc <= CRC_SEED;
      foot_cnt <= 1'b0;
    end else if (byte_stb) begin
      if (pstate == P_PAY || pstate == P_SKIP) begin
        remain <= remain - 17'h00001;
      end
      if (pstate == P_PAY) begin
        crc <= crc_byte(crc, byte_q);
      end
      if (pstate == P_CRC) begin
        foot_lo <= byte_q;
        foot_cnt <= ~foot_cnt;
      end
    end
  end

  // short packet delivery and event pulses.
  wire hdr_set = hdr_done && ecc_fatal;
  wire ovf_set = pay_stb && !buf_ready;
  wire foot_done = byte_stb && (pstate == P_CRC) && foot_cnt;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_short_valid <= 1'b0;
      o_short_id <= 8'h00;
      o_short_payload <= 16'h0000;
      o_long_type <= 6'h00;
      o_hdr_fixed <= 1'b0;
      o_crc_err <= 1'b0;
    end else begin
      o_short_valid <= hdr_done && hdr_keep && !hdr_long;
      o_hdr_fixed <= hdr_done && ecc_fixed;
      o_crc_err <= foot_done && ({byte_q, foot_lo} != crc);
      if (hdr_done && hdr_keep && !hdr_long) begin
        o_short_id <= hdr_fix[7:0];
        o_short_payload <= hdr_wc;
      end
      if (hdr_done && hdr_keep && hdr_long) begin
        o_long_type <= hdr_dt;
      end
    end
  end

  // sticky error flags.
  // A new error in the clearing cycle wins so no event is lost.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_hdr_err <= 1'b0;
      o_overflow <= 1'b0;
    end else begin
      o_hdr_err <= hdr_set || (o_hdr_err && !i_err_clr);
      o_overflow <= ovf_set || (o_overflow && !i_err_clr);
    end
  end

  a_vc_filter: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_short_valid |-> o_short_id[VC_MSB:VC_LSB] == VC_OWN)
    else $error("short packet on a foreign channel was delivered");

  a_type_filter: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_short_valid |-> is_host_type(o_short_id[DT_MSB:0]) && !is_long_type(o_short_id[DT_MSB:0]))
    else $error("unknown or long type delivered as short packet");

  a_hdr_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hdr_set |=> !o_short_valid && o_hdr_err && pstate != P_PAY)
    else $error("uncorrectable header was not dropped and flagged");

  a_err_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (hdr_set && i_err_clr) |=> o_hdr_err)
    else $error("header error lost in the clearing cycle");

  a_short_four: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (hdr_done && !ecc_fatal && !hdr_long) |=> pstate == P_HDR && hcnt == 2'h0)
    else $error("short packet did not end after four bytes");

  a_wc_low_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (hdr_done && hdr_keep && hdr_long) |=> remain[15:0] == {$past(byte_q, 1) ^ $past(byte_q, 1)
      ^ $past(hdr_fix[23:16]), $past(hdr_fix[15:8])})
    else $error("byte count not taken low byte first");

  // Turnaround timing and line drive.
  dpl_bstate_t bstate;
  dpl_bstate_t next_bstate;
  logic [7:0] tmr;
  wire lpx_done = (tmr == 8'(LPX_CYC - 1));
  wire go_done = (tmr == 8'(BTA_GO_CYC - 1));

  // request detection, take and hand back.
  // A bare 11-10-00 prefix is shared with escape entry, so the request
  // counts only when the far side holds LP-00 without moving to LP-01.
  always_comb begin
    next_bstate = bstate;
    unique case (bstate)
      B_LISTEN: if (lp_in == LP_11 && !burst) next_bstate = B_STOP;
      B_STOP: begin
        if (lp_in == LP_10) next_bstate = B_SAW10;
        else if (lp_in != LP_11) next_bstate = B_LISTEN;
      end
      B_SAW10: begin
        if (lp_in == LP_00) next_bstate = B_SAW00;
        else if (lp_in == LP_11) next_bstate = B_STOP;
        else if (lp_in != LP_10) next_bstate = B_LISTEN;
      end
      B_SAW00: begin
        if (lp_in != LP_00) next_bstate = B_LISTEN;
        else if (go_done) next_bstate = B_TAKE00;
      end
      B_TAKE00: if (lpx_done) next_bstate = B_TAKE10;
      B_TAKE10: if (lpx_done) next_bstate = B_OWN;
      B_OWN: if (i_give_back) next_bstate = B_GIVE10;
      B_GIVE10: if (lpx_done) next_bstate = B_GIVE00;
      B_GIVE00: if (lpx_done) next_bstate = B_LISTEN;
      default: next_bstate = B_LISTEN;
    endcase
  end

  // Step timer restarts on every state change.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bstate <= B_LISTEN;
      tmr <= 8'h00;
    end else begin
      bstate <= next_bstate;
      tmr <= (next_bstate != bstate) ? 8'h00 : tmr + 8'h01;
    end
  end

  // Registered line drive so the pins never glitch between steps.
  wire drive = (bstate == B_TAKE00) || (bstate == B_TAKE10) || (bstate == B_OWN)
    || (bstate == B_GIVE10) || (bstate == B_GIVE00);
  wire [1:0] level = (bstate == B_TAKE10 || bstate == B_GIVE10) ? LP_10
    : (bstate == B_OWN) ? LP_11 : LP_00;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_lp_oe <= 1'b0;
      o_lp_dp <= 1'b1;
      o_lp_dn <= 1'b1;
      o_lane_owned <= 1'b0;
    end else begin
      o_lp_oe <= drive;
      o_lp_dp <= level[1];
      o_lp_dn <= level[0];
      o_lane_owned <= (bstate == B_OWN);
    end
  end

  a_take_seq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_lp_oe) |-> (!o_lp_dp && !o_lp_dn)[*5] ##1 (o_lp_dp && !o_lp_dn)[*5]
      ##1 (o_lp_dp && o_lp_dn && o_lane_owned))
    else $error("takeover did not step LP-00, LP-10, LP-11");

  a_req_seen: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_lp_oe) |-> $past(lp_in, 2) == LP_00 && $past(bstate, 2) == B_SAW00)
    else $error("lane taken without a turnaround request");

  a_give_back: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_lp_oe) |-> $past(o_lp_dp, 6) && !$past(o_lp_dn, 6) && !$past(o_lp_dp, 1))
    else $error("lane released without LP-10 then LP-00");

endmodule

/* File: dpl_rx_top_tb_top.sv */
// Self-checking bench for the packet receiver and lane-0 turnaround.
// Assumes dpl_pkg and the host model; expectations queue up as packets are built.
`timescale 1ns/1ns
module dpl_rx_top_tb_top;
  import dpl_pkg::*;
  localparam logic [5:0] HOST_DT [23] = '{6'h01, 6'h11, 6'h21, 6'h31, 6'h08, 6'h03, 6'h13,
    6'h23, 6'h04, 6'h14, 6'h24, 6'h05, 6'h15, 6'h06, 6'h37, 6'h09, 6'h19, 6'h29, 6'h39,
    6'h3e, 6'h0e, 6'h1e, 6'h2e};
  logic i_clk_sys, i_rst, i_give_back, i_data_ready, i_err_clr, hold;
  logic i_link_clk, i_burst, i_lane_bit, host_oe, o_lp_dp, o_lp_dn, o_lp_oe, o_lane_owned;
  logic o_short_valid, o_data_last, o_data_valid, o_hdr_fixed, o_crc_err, o_hdr_err;
  logic o_overflow;
  logic [1:0] host_lp, lane;
  logic [7:0] o_short_id, o_data;
  logic [15:0] o_short_payload;
  logic [5:0] o_long_type;
  logic [7:0] bq[$];
  logic [24:0] sq[$];
  logic [14:0] dq[$];
  logic cq[$];
  logic [31:0] seed = 32'd78476;
  int bad_count = 0;
  int num_checks = 0;

  // Whoever drives lane 0 sets its level; an undriven line shows the inverse.
  assign lane = o_lp_oe ? {o_lp_dp, o_lp_dn} : (host_oe ? host_lp : ~host_lp);

  dpl_host_model host (.i_clk_sys, .i_lp_oe(o_lp_oe), .o_link_clk(i_link_clk),
    .o_burst(i_burst), .o_lane_bit(i_lane_bit), .o_host_oe(host_oe), .o_host_lp(host_lp));

  dpl_rx_top dut (.i_clk_sys, .i_rst, .i_link_clk, .i_burst, .i_lane_bit,
    .i_lp_dp(lane[1]), .i_lp_dn(lane[0]), .o_lp_dp, .o_lp_dn, .o_lp_oe, .o_lane_owned,
    .i_give_back, .o_short_valid, .o_short_id, .o_short_payload, .o_long_type, .o_data,
    .o_data_last, .o_data_valid, .i_data_ready, .o_hdr_fixed, .o_crc_err, .o_hdr_err,
    .o_overflow, .i_err_clr);

  // Clock at 100 MHz.
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // header bytes: id, low, high, check
  task automatic add_hdr(input logic [7:0] di, input logic [15:0] w, input logic [31:0] flip);
    logic [31:0] h;
    logic [7:0] p;
    p = 8'h00;
    for (int k = 0; k < 6; k++) p[k] = ^({w, di} & ECC_MASK[k]);
    h = {p, w, di} ^ flip;
    for (int i = 0; i < 4; i++) bq.push_back(h[8*i +: 8]);
  endtask

  task automatic add_short(input logic [7:0] di, input logic [15:0] w, input logic acc,
                           input logic [31:0] flip);
    add_hdr(di, w, flip);
    if (acc) sq.push_back({|flip, di, w});
  endtask

  // payload then footer, low byte first; keep bounds expected bytes.
  task automatic add_long(input logic [7:0] di, input int n, input logic bad, input int keep);
    logic [15:0] c;
    logic [7:0] b;
    c = CRC_SEED;
    add_hdr(di, 16'(n), 32'h0);
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      bq.push_back(b);
      if (i < keep) dq.push_back({di[5:0], i == n - 1, b});
      for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
    end
    c[0] ^= bad;
    bq.push_back(c[7:0]);
    bq.push_back(c[15:8]);
    if (bad) cq.push_back(1'b1);
  endtask

  task automatic send();
    host.burst(bq);
    bq.delete();
  endtask

  // Bounded drain: every note taken and the buffer empty.
  task automatic drain();
    for (int n = 0; n < 3000 && (sq.size() + dq.size() + cq.size() > 0 || o_data_valid);
         n++) @(posedge i_clk_sys);
    chk("drained", 0, sq.size() + dq.size() + cq.size());
    chk("buf_empty", 0, o_data_valid);
    if (bad_count != 0) tally_and_finish();
  endtask

  task automatic clr_flags();
    i_err_clr <= 1'b1;
    @(posedge i_clk_sys) i_err_clr <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    chk("flags", 0, {o_hdr_err, o_overflow});
  endtask

  // The user accepts payload at random unless the bench stalls it.
  always @(posedge i_clk_sys) i_data_ready <= !hold && (rnd() % 3 != 0);

  // Each result takes the oldest note off its queue.
  always @(posedge i_clk_sys) begin
    if (o_short_valid === 1'b1) begin
      if (sq.size() == 0) chk("short_extra", 0, 1);
      else chk("short", sq.pop_front(), {o_hdr_fixed, o_short_id, o_short_payload});
    end
    if (o_data_valid === 1'b1 && i_data_ready === 1'b1) begin
      if (dq.size() == 0) chk("data_extra", 0, 1);
      else chk("data", dq.pop_front(), {o_long_type, o_data_last, o_data});
    end
    if (o_crc_err === 1'b1) begin
      if (cq.size() == 0) chk("crc_extra", 0, 1);
      else chk("crc_err", cq.pop_front(), o_crc_err);
    end
  end

  initial begin
    i_rst = 1'b1;
    i_give_back = 1'b0;
    i_err_clr = 1'b0;
    hold = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    // every host type in one burst
    foreach (HOST_DT[i]) begin
      if (HOST_DT[i][3:0] == 4'h9 || HOST_DT[i][3:0] == 4'he)
        add_long({2'b00, HOST_DT[i]}, i % 4, 1'b0, 99);
      else
        add_short({2'b00, HOST_DT[i]}, 16'(rnd()), 1'b1, 32'h0);
    end
    send();
    // other channels dropped, long one skipped whole
    for (int v = 1; v < 4; v++) add_short({2'(v), 6'h05}, 16'(rnd()), 1'b0, 32'h0);
    add_long(8'h69, 2, 1'b0, 0);
    add_short(8'h02, 16'h1234, 1'b0, 32'h0);
    add_short(8'h15, 16'h0035, 1'b1, 32'h0);
    add_long(8'h39, 3, 1'b1, 3);
    send();
    drain();
    // single flips corrected, double flip drops the rest of the burst
    add_short(8'h05, 16'h0010, 1'b1, 32'h0000_0200);
    add_short(8'h23, 16'(rnd()), 1'b1, 32'h0400_0000);
    add_short(8'h15, 16'h5a5a, 1'b0, 32'h0000_0101);
    add_short(8'h05, 16'h0001, 1'b0, 32'h0);
    send();
    chk("hdr_err", 1, o_hdr_err);
    clr_flags();
    // Stalled user: two entries fill, the third and fourth bytes are lost.
    hold <= 1'b1;
    add_long(8'h29, 4, 1'b0, 2);
    send();
    chk("overflow", 1, o_overflow);
    hold <= 1'b0;
    drain();
    clr_flags();
    // turnaround: LP-00, LP-10, stop state and ownership
    fork
      host.turnaround();
      begin
        for (int n = 0; n < 300 && o_lp_oe !== 1'b1; n++) @(posedge i_clk_sys);
        chk("bta_00", {1'b1, LP_00}, {o_lp_oe, lane});
        repeat (5) @(posedge i_clk_sys);
        chk("bta_10", {1'b1, LP_10}, {o_lp_oe, lane});
        repeat (5) @(posedge i_clk_sys);
        chk("bta_11", {2'b11, LP_11}, {o_lane_owned, o_lp_oe, lane});
      end
    join
    i_give_back <= 1'b1;
    @(posedge i_clk_sys) i_give_back <= 1'b0;
    for (int n = 0; n < 40 && o_lp_oe !== 1'b0; n++) @(posedge i_clk_sys);
    chk("released", 0, {o_lp_oe, o_lane_owned});
    chk("host_wait", 0, host.to_err);
    tally_and_finish();
  end
endmodule

/* File: dpl_skid_buf.sv */
// Small valid/ready buffer between the payload extractor and the user.
// The filling side sees o_ready low when every entry is occupied.
`timescale 1ns/1ns
module dpl_skid_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Elaboration check: the wrap and full logic assume two or more entries.
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("dpl_skid_buf needs at least two entries and one bit");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] fill;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  // Honest flags straight from the occupancy count.
  assign o_ready = (fill != (AW+1)'(DEPTH));
  assign o_valid = (fill != '0);
  assign o_data = mem[rd_idx];

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage is written only, never reset, to keep it cheap.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_idx] <= i_data;
    end
  end

endmodule
